// ==== common/serial_adc_pkg.sv ====
// Shared constants and types for the serial converter link and its master.
package serial_adc_pkg;

	// ------------------------------------------------------------------
	// Conversion format
	// ------------------------------------------------------------------
	localparam int             CODE_W         = 10;
	localparam int             LEVEL_W        = 16;
	localparam int             CODE_STEPS     = 1024;
	localparam int             LSB_SHIFT      = 6;
	localparam logic [16:0]    HALF_LSB_UNITS = 17'h00020;
	localparam logic [10:0]    CODE_MAX       = 11'h3ff;

	// ------------------------------------------------------------------
	// Frame positions, counted in serial clock falling edges
	// ------------------------------------------------------------------
	localparam int             FALL_W           = 5;
	localparam logic [4:0]     SHUTDOWN_MIN_FALL = 5'h02;
	localparam logic [4:0]     NORMAL_HOLD_FALL  = 5'h0a;
	localparam logic [4:0]     DATA_FIRST_FALL   = 5'h04;
	localparam logic [4:0]     DATA_LAST_FALL    = 5'h0d;
	localparam logic [4:0]     WORD_FALLS        = 5'h10;
	localparam logic [4:0]     SAVE_LAST_FALL    = 5'h0e;
	localparam logic [4:0]     CONT_FRAME_FALLS  = 5'h14;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int             CLK_PERIOD_NS  = 100;
	localparam int             SCLK_PERIOD_NS = 800;
	localparam int             SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int             QUIET_NS       = 50;
	localparam int             QUIET_RAW      = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int             QUIET_CYC      = (QUIET_RAW < 1) ? 1 : QUIET_RAW;
	localparam int             TIMER_W        = 4;

	// ------------------------------------------------------------------
	// Modes and states
	// ------------------------------------------------------------------
	typedef enum logic {MODE_NORMAL, MODE_SHUTDOWN} power_mode_t;
	typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_GAP} host_state_t;

endpackage : serial_adc_pkg

// ==== common/adc_link_if.sv ====
// Three-wire link between the converter end and its serial master.
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
	logic sclk;
	logic cs_n;
	logic serial_result_out;
	logic serial_result_oe;
	logic serial_result_level;

	// A released line is read as high, as if a weak pull-up held it.
	assign serial_result_level = serial_result_oe ? serial_result_out : 1'b1;

	modport device_end (
		input  sclk,
		input  cs_n,
		output serial_result_out,
		output serial_result_oe
	);

	modport host_end (
		output sclk,
		output cs_n,
		input  serial_result_level
	);
endinterface : adc_link_if
`default_nettype wire

// ==== verilog/serial_adc_device.sv ====
// Converter end: frame decoding, power modes and result shifting.
//
// What this block and its master do
// - Result is unsigned binary, step is reference/1024.
// - First step at half LSB, then full steps.
// - Select fall enters normal mode, starts conversion.
// - Rise after falls 2..9 shuts down, aborts.
// - Rise before fall 2 keeps power mode.
// - Rise after falls 10..15 aborts, stays normal.
// - Shutdown holds analog off until select falls.
// - Frame from shutdown gives unusable dummy result.
// - Wake frame needs select low past fall 10.
// - Fully powered after sixteen wake-frame clocks.
// - Sixteen clocks per word, then line released.
// - Master raises select before next frame.
// - Master keeps quiet gap before next frame.
// - Quiet gap also follows the dummy conversion.
// - Power-on mode unknown; run one dummy first.
// - Continuous normal operation uses 20-clock frames.
// - Power saving: rise between falls 2 and 9.
// - Four zeros, ten bits MSB first, two zeros.
// - Master captures each data bit at end of following high phase.
// - Select fall drives line and samples input.
`timescale 1ns/1ps
`default_nettype none
module serial_adc_device
	import serial_adc_pkg::*;
#(
	parameter power_mode_t START_MODE = MODE_SHUTDOWN
) (
	input  wire logic                clk,
	input  wire logic                reset,
	adc_link_if.device_end           link,
	input  wire logic [LEVEL_W-1:0]  analog_level,
	output logic      [CODE_W-1:0]   last_code,
	output logic                     analog_on,
	output logic                     powered_up,
	output logic                     frame_active,
	output logic                     frame_aborted
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------

	// The level is a fraction of the supply reference in 2^16 units, so
	// one code step is 64 units and the half-step offset centres codes.
	function automatic logic [CODE_W-1:0] quantise(
		input logic [LEVEL_W-1:0] level
	);
		logic [16:0] sum;
		logic [10:0] steps;
		sum   = {1'b0, level} + HALF_LSB_UNITS;
		steps = sum[16:LSB_SHIFT];
		if (steps > CODE_MAX) begin
			steps = CODE_MAX;
		end
		return steps[CODE_W-1:0];
	endfunction : quantise

	// Bit driven after a given falling edge of the frame.
	function automatic logic frame_bit(
		input logic [FALL_W-1:0] fall,
		input logic [CODE_W-1:0] code
	);
		logic [4:0] idx;
		idx = DATA_LAST_FALL - fall;
		frame_bit = 1'b0;
		if (fall >= DATA_FIRST_FALL && fall <= DATA_LAST_FALL) begin
			frame_bit = code[idx[3:0]];
		end
	endfunction : frame_bit

	// ------------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------------
	logic [1:0] sclk_sync_ff;
	logic [1:0] cs_sync_ff;
	logic       sclk_d_ff;
	logic       cs_d_ff;
	logic       sclk_fall;
	logic       cs_fall;
	logic       cs_rise;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sclk_sync_ff <= 2'h3;
			cs_sync_ff   <= 2'h3;
			sclk_d_ff    <= 1'b1;
			cs_d_ff      <= 1'b1;
		end else begin
			sclk_sync_ff <= {sclk_sync_ff[0], link.sclk};
			cs_sync_ff   <= {cs_sync_ff[0], link.cs_n};
			sclk_d_ff    <= sclk_sync_ff[1];
			cs_d_ff      <= cs_sync_ff[1];
		end
	end

	assign sclk_fall = sclk_d_ff & ~sclk_sync_ff[1];
	assign cs_fall   = cs_d_ff & ~cs_sync_ff[1];
	assign cs_rise   = ~cs_d_ff & cs_sync_ff[1];

	// ------------------------------------------------------------------
	// Frame tracking
	// ------------------------------------------------------------------
	logic              active_ff;
	logic [FALL_W-1:0] fall_cnt_ff;
	logic [FALL_W-1:0] nxt_fall_cnt;
	logic              counting;

	assign counting     = active_ff & sclk_fall & (fall_cnt_ff < WORD_FALLS);
	assign nxt_fall_cnt = fall_cnt_ff + 5'h01;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			active_ff   <= 1'b0;
			fall_cnt_ff <= '0;
		end else if (cs_fall) begin
			active_ff   <= 1'b1;
			fall_cnt_ff <= '0;
		end else if (cs_rise) begin
			active_ff   <= 1'b0;
		end else if (counting) begin
			fall_cnt_ff <= nxt_fall_cnt;
		end
	end

	// ------------------------------------------------------------------
	// Sample capture
	// ------------------------------------------------------------------
	logic [CODE_W-1:0] sample_ff;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sample_ff <= '0;
		end else if (cs_fall) begin
			sample_ff <= quantise(analog_level);
		end
	end

	// ------------------------------------------------------------------
	// Power mode
	// ------------------------------------------------------------------
	power_mode_t mode_ff;
	logic        wake_ff;
	logic        powering_ff;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_ff <= START_MODE;
			wake_ff <= 1'b0;
		end else if (cs_fall) begin
			mode_ff <= MODE_NORMAL;
			wake_ff <= (mode_ff == MODE_SHUTDOWN);
		end else if (cs_rise && active_ff) begin
			if (wake_ff && fall_cnt_ff < NORMAL_HOLD_FALL) begin
				mode_ff <= MODE_SHUTDOWN;
			end else if (fall_cnt_ff >= SHUTDOWN_MIN_FALL &&
					fall_cnt_ff < NORMAL_HOLD_FALL) begin
				mode_ff <= MODE_SHUTDOWN;
			end
			// Below two falls the mode is left alone, so select glitches
			// cannot switch it.
		end
	end

	// Until a full wake frame has run, results are not trusted; this
	// also covers the unknown state straight after power-on.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			powering_ff <= 1'b1;
		end else if (cs_fall && mode_ff == MODE_SHUTDOWN) begin
			powering_ff <= 1'b1;
		end else if (counting && nxt_fall_cnt == WORD_FALLS) begin
			powering_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Result line
	// ------------------------------------------------------------------
	logic sdo_ff;
	logic oe_ff;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sdo_ff <= 1'b0;
			oe_ff  <= 1'b0;
		end else if (cs_fall) begin
			sdo_ff <= 1'b0;
			oe_ff  <= 1'b1;
		end else if (cs_rise) begin
			oe_ff  <= 1'b0;
		end else if (counting) begin
			if (nxt_fall_cnt == WORD_FALLS) begin
				oe_ff <= 1'b0;
			end else begin
				sdo_ff <= frame_bit(nxt_fall_cnt, sample_ff);
			end
		end
	end

	// ------------------------------------------------------------------
	// Status outputs
	// ------------------------------------------------------------------
	logic aborted_ff;
	logic [CODE_W-1:0] last_code_ff;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			aborted_ff   <= 1'b0;
			last_code_ff <= '0;
		end else begin
			aborted_ff <= cs_rise & active_ff & (fall_cnt_ff < WORD_FALLS);
			if (counting && nxt_fall_cnt == WORD_FALLS) begin
				last_code_ff <= sample_ff;
			end
		end
	end

	assign link.serial_result_out = sdo_ff;
	assign link.serial_result_oe  = oe_ff;
	assign last_code     = last_code_ff;
	assign analog_on     = (mode_ff == MODE_NORMAL);
	assign powered_up    = (mode_ff == MODE_NORMAL) & ~powering_ff;
	assign frame_active  = active_ff;
	assign frame_aborted = aborted_ff;

endmodule : serial_adc_device
`default_nettype wire

// ==== verilog/serial_adc_host.sv ====
// Serial master end: makes the serial clock and frames, collects words.
`timescale 1ns/1ps
`default_nettype none
module serial_adc_host
	import serial_adc_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                reset,
	adc_link_if.host_end             link,
	input  wire logic                start,
	input  wire logic [FALL_W-1:0]   frame_len,
	output logic                     ready,
	output logic      [CODE_W-1:0]   result,
	output logic                     result_valid,
	output logic                     result_dummy,
	output logic                     maybe_shutdown
);

	localparam logic [TIMER_W-1:0] HALF_LOAD  = TIMER_W'(SCLK_HALF_CYC - 1);
	localparam logic [TIMER_W-1:0] QUIET_LOAD = TIMER_W'(QUIET_CYC - 1);

	// ------------------------------------------------------------------
	// Result line synchroniser
	// ------------------------------------------------------------------
	logic [1:0] result_sync_ff;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			result_sync_ff <= 2'h3;
		end else begin
			result_sync_ff <= {result_sync_ff[0], link.serial_result_level};
		end
	end

	// ------------------------------------------------------------------
	// Frame sequencer
	// ------------------------------------------------------------------
	host_state_t        state_ff;
	logic [TIMER_W-1:0] timer_ff;
	logic [FALL_W-1:0]  fall_cnt_ff;
	logic [FALL_W-1:0]  len_ff;
	logic               sclk_ff;
	logic               cs_n_ff;
	logic               tick;
	logic               frame_end;

	assign tick      = (timer_ff == '0);
	assign frame_end = tick && ((state_ff == H_LEAD && len_ff == '0) ||
		(state_ff == H_HIGH && fall_cnt_ff == len_ff));

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_ff    <= H_IDLE;
			timer_ff    <= '0;
			fall_cnt_ff <= '0;
			len_ff      <= '0;
			sclk_ff     <= 1'b1;
			cs_n_ff     <= 1'b1;
		end else begin
			timer_ff <= tick ? '0 : timer_ff - 4'h1;
			unique case (state_ff)
				H_IDLE: begin
					if (start) begin
						cs_n_ff     <= 1'b0;
						len_ff      <= frame_len;
						fall_cnt_ff <= '0;
						timer_ff    <= HALF_LOAD;
						state_ff    <= H_LEAD;
					end
				end
				H_LEAD, H_HIGH: begin
					if (frame_end) begin
						// Always released, even after a full word.
						cs_n_ff  <= 1'b1;
						timer_ff <= QUIET_LOAD;
						state_ff <= H_GAP;
					end else if (tick) begin
						sclk_ff     <= 1'b0;
						fall_cnt_ff <= fall_cnt_ff + 5'h01;
						timer_ff    <= HALF_LOAD;
						state_ff    <= H_LOW;
					end
				end
				H_LOW: begin
					if (tick) begin
						sclk_ff  <= 1'b1;
						timer_ff <= HALF_LOAD;
						state_ff <= H_HIGH;
					end
				end
				H_GAP: begin
					if (tick) begin
						state_ff <= H_IDLE;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Capture and word assembly
	// ------------------------------------------------------------------

	// The bit is taken at the end of the high phase rather than right at
	// the rising edge: the synchroniser and the far end's own sampling
	// delay would otherwise eat the whole setup margin.
	logic [CODE_W-1:0] shift_ff;
	logic [CODE_W-1:0] result_ff;
	logic              valid_ff;
	logic              dummy_ff;
	logic              frame_dummy_ff;
	logic              maybe_sd_ff;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			shift_ff <= '0;
		end else if (state_ff == H_HIGH && tick &&
				fall_cnt_ff >= DATA_FIRST_FALL &&
				fall_cnt_ff <= DATA_LAST_FALL) begin
			shift_ff <= {shift_ff[CODE_W-2:0], result_sync_ff[1]};
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			maybe_sd_ff    <= 1'b1;
			frame_dummy_ff <= 1'b1;
		end else if (state_ff == H_IDLE && start) begin
			frame_dummy_ff <= maybe_sd_ff;
		end else if (frame_end) begin
			if (frame_dummy_ff && len_ff < NORMAL_HOLD_FALL) begin
				maybe_sd_ff <= 1'b1;
			end else if (len_ff >= SHUTDOWN_MIN_FALL &&
					len_ff < NORMAL_HOLD_FALL) begin
				maybe_sd_ff <= 1'b1;
			end else if (len_ff >= NORMAL_HOLD_FALL) begin
				maybe_sd_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			result_ff <= '0;
			valid_ff  <= 1'b0;
			dummy_ff  <= 1'b0;
		end else begin
			valid_ff <= frame_end && (len_ff >= WORD_FALLS);
			if (frame_end && len_ff >= WORD_FALLS) begin
				result_ff <= shift_ff;
				dummy_ff  <= frame_dummy_ff;
			end
		end
	end

	assign link.sclk      = sclk_ff;
	assign link.cs_n      = cs_n_ff;
	assign ready          = (state_ff == H_IDLE);
	assign result         = result_ff;
	assign result_valid   = valid_ff;
	assign result_dummy   = dummy_ff;
	assign maybe_shutdown = maybe_sd_ff;

endmodule : serial_adc_host
`default_nettype wire

// ==== testbench/serial_adc_link_assertions.sv ====
// Checker for the wire between the converter end and its serial master.
`timescale 1ns/1ps
`default_nettype none
module serial_adc_link_assertions (
	input wire logic clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic serial_result_out,
	input wire logic serial_result_oe
);
	logic [3:0] sclk_hist_ff;
	logic [4:0] fall_cnt_ff;
	logic       fall_now;

	assign fall_now = sclk_hist_ff[0] && !sclk && !cs_n;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sclk_hist_ff <= 4'hf;
		end else begin
			sclk_hist_ff <= {sclk_hist_ff[2:0], sclk};
		end
	end

	// Saturates so that an over-long frame cannot wrap back to fall one.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fall_cnt_ff <= 5'h00;
		end else if (cs_n) begin
			fall_cnt_ff <= 5'h00;
		end else if (fall_now && fall_cnt_ff != 5'h1f) begin
			fall_cnt_ff <= fall_cnt_ff + 5'h01;
		end
	end

	// ------------------------------------------------------------------
	// Wire properties
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_zero_after3;
		##3 !(serial_result_oe && serial_result_out);
	endsequence
	sequence s_released_after3;
		##3 !serial_result_oe;
	endsequence

	a_drive_on_start: assert property (
		$fell(cs_n) |-> ##3 (serial_result_oe && !serial_result_out))
		else $error("line not driven low after select fall");
	a_lead_zeros: assert property (
		fall_now && fall_cnt_ff < 5'h03 |-> s_zero_after3)
		else $error("leading bit not zero");
	a_tail_zeros: assert property (
		fall_now && fall_cnt_ff inside {5'h0d, 5'h0e} |-> s_zero_after3)
		else $error("trailing bit not zero");
	a_word_release: assert property (
		fall_now && fall_cnt_ff >= 5'h0f |-> s_released_after3)
		else $error("line still driven after word end");
	a_abort_release: assert property (
		$rose(cs_n) |-> s_released_after3)
		else $error("line still driven after select rise");
	a_idle_released: assert property (
		cs_n [*4] |-> !serial_result_oe)
		else $error("line driven while not selected");
	a_shift_on_fall: assert property (
		serial_result_oe && $past(serial_result_oe) &&
		$changed(serial_result_out) |-> sclk_hist_ff[3] && !sclk_hist_ff[2])
		else $error("bit changed away from a clock fall");
	a_clock_idle: assert property (
		cs_n && $past(cs_n) |-> sclk)
		else $error("serial clock moves outside a frame");
	a_low_phase: assert property (
		$fell(sclk) |-> (!sclk) [*4])
		else $error("serial clock low phase too short");
	a_quiet_gap: assert property (
		$rose(cs_n) |-> cs_n [*2])
		else $error("select lowered without quiet gap");
endmodule : serial_adc_link_assertions
`default_nettype wire

// ==== testbench/serial_adc_mode_control_tb_top.sv ====
// Testbench joining the converter end and its master over one link.
`timescale 1ns/1ps
`default_nettype none
module serial_adc_mode_control_tb_top
	import serial_adc_pkg::*;
;
	logic                clk;
	logic                reset;
	logic                start;
	logic [FALL_W-1:0]   frame_len;
	logic [LEVEL_W-1:0]  analog_level;
	logic [CODE_W-1:0]   last_code;
	logic [CODE_W-1:0]   result;
	logic                analog_on, powered_up, frame_active, frame_aborted;
	logic                ready, result_valid, result_dummy, maybe_shutdown;
	logic [15:0]         valid_seen, abort_seen;
	logic [15:0]         valid_total = 16'h0000;
	logic [15:0]         abort_total = 16'h0000;
	int                  error_cnt = 0;
	int                  checks = 0;

	adc_link_if adc_link_if_i ();

	serial_adc_device serial_adc_device_i (
		.clk(clk), .reset(reset), .link(adc_link_if_i.device_end),
		.analog_level(analog_level), .last_code(last_code),
		.analog_on(analog_on), .powered_up(powered_up),
		.frame_active(frame_active), .frame_aborted(frame_aborted));

	serial_adc_host serial_adc_host_i (
		.clk(clk), .reset(reset), .link(adc_link_if_i.host_end),
		.start(start), .frame_len(frame_len), .ready(ready),
		.result(result), .result_valid(result_valid),
		.result_dummy(result_dummy), .maybe_shutdown(maybe_shutdown));

	serial_adc_link_assertions serial_adc_link_assertions_i (
		.clk(clk), .reset(reset), .sclk(adc_link_if_i.sclk),
		.cs_n(adc_link_if_i.cs_n),
		.serial_result_out(adc_link_if_i.serial_result_out),
		.serial_result_oe(adc_link_if_i.serial_result_oe));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		if (result_valid === 1'b1) valid_total++;
		if (frame_aborted === 1'b1) abort_total++;
	end

	// One step is 64 input units; the first step sits half a step up.
	function automatic logic [15:0] code_of(input logic [15:0] lv);
		logic [16:0] s;
		s = {1'b0, lv} + 17'h00020;
		return (s[16:6] > 11'h3ff) ? 16'h03ff : {6'h00, s[15:6]};
	endfunction : code_of

	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic run_frame(input logic [4:0] len, input logic [15:0] lv);
		int n;
		logic [15:0] v0;
		logic [15:0] a0;
		// The pulse counters run free; each frame is judged by the
		// difference, so only the clocked counter ever writes them.
		n = 0;
		v0 = valid_total;
		a0 = abort_total;
		analog_level = lv;
		frame_len = len;
		start = 1'b1;
		@(posedge clk);
		#1;
		start = 1'b0;
		while (ready !== 1'b1 && n < 400) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 400) check("ready", 16'h0001, {15'h0000, ready});
		repeat (6) @(posedge clk);
		#1;
		valid_seen = valid_total - v0;
		abort_seen = abort_total - a0;
		check("frame_active", 16'h0000, frame_active);
	endtask : run_frame

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_wake_dummy();
		check("maybe_shutdown", 16'h0001, maybe_shutdown);
		check("analog_on", 16'h0000, analog_on);
		run_frame(5'h10, 16'h1234);
		check("valid", 16'h0001, valid_seen);
		check("dummy", 16'h0001, result_dummy);
		check("analog_on", 16'h0001, analog_on);
		check("powered_up", 16'h0001, powered_up);
		check("maybe_shutdown", 16'h0000, maybe_shutdown);
		run_frame(5'h10, 16'h8000);
		check("dummy", 16'h0000, result_dummy);
		check("result", code_of(16'h8000), result);
		$display("test wake_dummy done");
	endtask : t_wake_dummy

	task automatic t_codes();
		logic [15:0] lv [8];
		lv = '{16'h0000, 16'h001f, 16'h0020, 16'h005f,
			16'h0060, 16'h7fdf, 16'hffdf, 16'hffff};
		for (int i = 0; i < 8; i++) begin
			run_frame(i[0] ? 5'h14 : 5'h10, lv[i]);
			check("valid", 16'h0001, valid_seen);
			check("result", code_of(lv[i]), result);
			check("last_code", code_of(lv[i]), last_code);
		end
		$display("test codes done");
	endtask : t_codes

	task automatic t_abort_normal();
		logic [4:0] lens [4];
		lens = '{5'h0a, 5'h0f, 5'h00, 5'h01};
		for (int i = 0; i < 4; i++) begin
			run_frame(lens[i], 16'h4000);
			check("valid", 16'h0000, valid_seen);
			check("abort", 16'h0001, abort_seen);
			check("analog_on", 16'h0001, analog_on);
			check("result", 16'h03ff, result);
		end
		$display("test abort_normal done");
	endtask : t_abort_normal

	task automatic t_shutdown();
		run_frame(5'h02, 16'h0100);
		check("analog_on", 16'h0000, analog_on);
		check("abort", 16'h0001, abort_seen);
		check("maybe_shutdown", 16'h0001, maybe_shutdown);
		repeat (40) @(posedge clk);
		#1;
		check("analog_on", 16'h0000, analog_on);
		run_frame(5'h01, 16'h0100);
		check("analog_on", 16'h0000, analog_on);
		run_frame(5'h09, 16'h0100);
		check("analog_on", 16'h0000, analog_on);
		run_frame(5'h0a, 16'h0100);
		check("analog_on", 16'h0001, analog_on);
		check("powered_up", 16'h0000, powered_up);
		run_frame(5'h10, 16'h0040);
		check("powered_up", 16'h0001, powered_up);
		check("result", code_of(16'h0040), result);
		run_frame(5'h09, 16'h0100);
		check("analog_on", 16'h0000, analog_on);
		run_frame(5'h10, 16'h2000);
		check("dummy", 16'h0001, result_dummy);
		$display("test shutdown done");
	endtask : t_shutdown

	initial begin
		#3000000;
		error_cnt++;
		$display("CHECK FAILED watchdog expected end seen hang");
		final_report();
	end

	initial begin
		start = 1'b0;
		frame_len = 5'h00;
		analog_level = 16'h0000;
		valid_seen = 16'h0000;
		abort_seen = 16'h0000;
		reset = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		reset = 1'b0;
		t_wake_dummy();
		t_codes();
		t_abort_normal();
		t_shutdown();
		final_report();
	end
endmodule : serial_adc_mode_control_tb_top
`default_nettype wire
